// [common/dtf_pkg.sv]
// Purpose: shared constants and types of the delay timer functions
// Assumes: 100 MHz clk_sys
// Notes: spans count in ticks of the selected time base
package dtf_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TICK_10MS_US = 10000;
	localparam int TICK_1S_US = 1000000;
	localparam int TICK_1MIN_US = 60000000;
	localparam int CYC_10MS = TICK_10MS_US * CLK_MHZ;
	localparam int CYC_1S = TICK_1S_US * CLK_MHZ;
	// one minute of cycles overflows a 32-bit int
	localparam longint CYC_1MIN = longint'(TICK_1MIN_US) * CLK_MHZ;
	localparam int SPAN_W = 17;
	// constant span limits, in ticks
	localparam logic [16:0] MAX_CONST_SEC = 17'h0270f;
	localparam logic [16:0] MAX_CONST_MIN = 17'h01770 - 17'h00001;
	// referenced span limits
	localparam logic [16:0] MAX_REF_MS = 17'h18696;
	localparam logic [16:0] MAX_REF_SM = 17'h0176f;
	localparam logic [16:0] SPAN_RESET = 17'h00000;
	localparam int MS_PER_TICK = 10;
	typedef enum logic [1:0] {
		DTF_BASE_FAST,
		DTF_BASE_SEC,
		DTF_BASE_MIN
	} dtf_base_type;
	typedef enum logic {
		DTF_MODE_ONOFF,
		DTF_MODE_RETON
	} dtf_mode_type;
endpackage

// [common/dtf_tick_if.sv]
// Purpose: carries base ticks from the tick source to the timer
// Assumes: single clock domain
// Notes: ticks are one-cycle pulses
`timescale 1ns/1ps
interface dtf_tick_if;
	logic tick_10ms;
	logic tick_1s;
	logic tick_1min;
	modport source (output tick_10ms, output tick_1s, output tick_1min);
	modport sink (input tick_10ms, input tick_1s, input tick_1min);
endinterface

// [rtl/dtf_tick_gen.sv]
// Purpose: base tick generator
// Assumes: clk_sys at 100 MHz
// Notes: cascaded prescalers, one pulse per base period
`timescale 1ns/1ps
module dtf_tick_gen
	import dtf_pkg::*;
#(
	parameter int DIV_10MS = CYC_10MS,
	parameter int DIV_1S = TICK_1S_US / TICK_10MS_US,
	parameter int DIV_1MIN = TICK_1MIN_US / TICK_1S_US
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	dtf_tick_if.source ticks
);
	initial begin
		if (DIV_10MS < 1 || DIV_1S < 1 || DIV_1MIN < 1)
			$error("divider must be at least one");
		if (DIV_1S > 256 || DIV_1MIN > 256)
			$error("divider too large for 8-bit prescaler");
	end
	logic [31:0] cnt_a, next_cnt_a;
	logic [7:0] cnt_b, next_cnt_b;
	logic [7:0] cnt_c, next_cnt_c;
	logic t_a, t_b, t_c;
	always_comb begin
		t_a = (cnt_a == 32'(DIV_10MS - 1));
		t_b = t_a && (cnt_b == 8'(DIV_1S - 1));
		t_c = t_b && (cnt_c == 8'(DIV_1MIN - 1));
		next_cnt_a = t_a ? 32'h0 : cnt_a + 32'h1;
		next_cnt_b = cnt_b;
		next_cnt_c = cnt_c;
		if (t_a) begin
			next_cnt_b = t_b ? 8'h0 : cnt_b + 8'h1;
		end
		if (t_b) begin
			next_cnt_c = t_c ? 8'h0 : cnt_c + 8'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_a <= 32'h0;
			cnt_b <= 8'h0;
			cnt_c <= 8'h0;
		end else begin
			cnt_a <= next_cnt_a;
			cnt_b <= next_cnt_b;
			cnt_c <= next_cnt_c;
		end
	end
	assign ticks.tick_10ms = t_a;
	assign ticks.tick_1s = t_b;
	assign ticks.tick_1min = t_c;
endmodule

// [rtl/dtf_timer.sv]
// Purpose: on/off-delay and retentive on-delay timer function
// Assumes: inputs synchronous to clk_sys
// Notes: power loss is modelled by rst_n; retained state survives it
`timescale 1ns/1ps
// Operation
// - on/off mode: rising trigger starts on-delay timing
// - trigger high for full on-delay span sets output at expiry
// - trigger falls early: elapsed cleared, output not set
// - on/off mode: falling trigger starts off-delay timing
// - trigger low for full off-delay span clears output at expiry
// - trigger rises early: elapsed cleared, output stays high
// - retentivity selectable per instance
// - retentive: output and elapsed kept across power loss
// - not retentive: output and elapsed return to defaults
// - span is a constant or another block's live value
// - time base selectable per instance
// - retentive on-delay: rising trigger starts elapsed from zero
// - retentive on-delay: output set at elapsed equals span, then held
// - retentive on-delay: later trigger activity leaves elapsed alone
// - retentive on-delay: clear input clears output and elapsed
// - constant spans limited to 99:99 seconds or 99:59 minutes, hours
// - referenced spans limited to 99990 ms or 5999 s, min
// - out-of-range referenced span clamped to nearest valid value
module dtf_timer
	import dtf_pkg::*;
#(
	parameter bit RETENTIVE = 1'b0,
	parameter int DIV_10MS = CYC_10MS,
	parameter int DIV_1S = TICK_1S_US / TICK_10MS_US,
	parameter int DIV_1MIN = TICK_1MIN_US / TICK_1S_US
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire dtf_mode_type mode,
	input wire dtf_base_type time_base,
	input wire logic trigger_in,
	input wire logic clean_signal,
	input wire logic on_use_ref,
	input wire logic [SPAN_W-1:0] on_const_span,
	input wire logic [31:0] on_ref_value,
	input wire logic off_use_ref,
	input wire logic [SPAN_W-1:0] off_const_span,
	input wire logic [31:0] off_ref_value,
	output logic timer_out,
	output logic [SPAN_W-1:0] elapsed_span
);
	dtf_tick_if tick_bus();
	dtf_tick_gen #(
		.DIV_10MS(DIV_10MS),
		.DIV_1S(DIV_1S),
		.DIV_1MIN(DIV_1MIN)
	) u_tick (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ticks(tick_bus)
	);
	// constant spans: clamp to the base limit
	function automatic logic [SPAN_W-1:0] const_span(
		input logic [SPAN_W-1:0] v, input dtf_base_type b);
		logic [SPAN_W-1:0] lim;
		lim = (b == DTF_BASE_FAST) ? MAX_CONST_SEC : MAX_CONST_MIN;
		const_span = (v > lim) ? lim : v;
	endfunction
	// referenced spans: signed value clamped, ms turned into 10 ms ticks
	function automatic logic [SPAN_W-1:0] ref_span(
		input logic [31:0] v, input dtf_base_type b);
		logic [31:0] lim;
		logic [31:0] c;
		lim = (b == DTF_BASE_FAST) ? 32'(MAX_REF_MS) : 32'(MAX_REF_SM);
		if (v[31])
			c = 32'h0;
		else if (v > lim)
			c = lim;
		else
			c = v;
		if (b == DTF_BASE_FAST)
			c = c / 32'(MS_PER_TICK);
		ref_span = c[SPAN_W-1:0];
	endfunction
	logic tick;
	logic [SPAN_W-1:0] on_span, off_span;
	logic trig_d, rise, fall;
	logic running, next_running;
	logic next_timer_out;
	logic [SPAN_W-1:0] next_elapsed;
	always_comb begin
		case (time_base)
			DTF_BASE_FAST: tick = tick_bus.tick_10ms;
			DTF_BASE_SEC: tick = tick_bus.tick_1s;
			default: tick = tick_bus.tick_1min;
		endcase
		on_span = on_use_ref ? ref_span(on_ref_value, time_base)
			: const_span(on_const_span, time_base);
		off_span = off_use_ref ? ref_span(off_ref_value, time_base)
			: const_span(off_const_span, time_base);
		rise = trigger_in && !trig_d;
		fall = !trigger_in && trig_d;
	end
	always_comb begin
		next_running = running;
		next_timer_out = timer_out;
		next_elapsed = elapsed_span;
		if (mode == DTF_MODE_ONOFF) begin
			if (rise || fall) begin
				next_elapsed = SPAN_RESET;
				next_running = (rise && !timer_out) || (fall && timer_out);
			end else if (running && trigger_in && !timer_out) begin
				if (elapsed_span >= on_span) begin
					next_timer_out = 1'b1;
					next_running = 1'b0;
				end else if (tick) begin
					next_elapsed = elapsed_span + 1'b1;
				end
			end else if (running && !trigger_in && timer_out) begin
				if (elapsed_span >= off_span) begin
					next_timer_out = 1'b0;
					next_running = 1'b0;
				end else if (tick) begin
					next_elapsed = elapsed_span + 1'b1;
				end
			end else begin
				next_running = 1'b0;
			end
		end else begin
			if (clean_signal) begin
				next_timer_out = 1'b0;
				next_elapsed = SPAN_RESET;
				next_running = 1'b0;
			end else if (rise && !running && !timer_out) begin
				next_elapsed = SPAN_RESET;
				next_running = 1'b1;
			end else if (running) begin
				// trigger ignored while running
				if (elapsed_span >= on_span) begin
					next_timer_out = 1'b1;
					next_running = 1'b0;
				end else if (tick) begin
					next_elapsed = elapsed_span + 1'b1;
				end
			end
		end
	end
	// state kept across reset when retentive
	always_ff @(posedge clk_sys) begin
		if (!rst_n && !RETENTIVE) begin
			timer_out <= 1'b0;
			elapsed_span <= SPAN_RESET;
			running <= 1'b0;
			trig_d <= 1'b0;
		end else if (!rst_n) begin
			trig_d <= trigger_in;
		end else begin
			timer_out <= next_timer_out;
			elapsed_span <= next_elapsed;
			running <= next_running;
			trig_d <= trigger_in;
		end
	end
endmodule

// [tb/dtf_nbr_blk.sv]
// Purpose: neighbour block offering a live value
// Assumes: clk_sys domain
// Notes: value follows load one edge later
`timescale 1ns/1ps
module dtf_nbr_blk (
	input wire logic clk_sys,
	input wire logic [31:0] load,
	output logic [31:0] live
);
	always_ff @(posedge clk_sys) begin
		live <= load;
	end
endmodule

// [tb/dtf_timer_chk.sv]
// Purpose: port checks of the delay timer
// Assumes: sync active-low reset
// Notes: bound to every timer instance
`timescale 1ns/1ps
module dtf_timer_chk
	import dtf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire dtf_mode_type mode,
	input wire logic trigger_in,
	input wire logic clean_signal,
	input wire logic timer_out,
	input wire logic [SPAN_W-1:0] elapsed_span
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	logic on_m;
	assign on_m = mode == DTF_MODE_ONOFF;
	rise_trig_a: assert property (on_m && $rose(timer_out)
		|-> $past(trigger_in)) else $error("rise with trigger low");
	fall_low_a: assert property (on_m && $fell(timer_out)
		&& $past(rst_n) |-> !$past(trigger_in)) else $error("fall too soon");
	edge_clr_a: assert property (on_m && $changed(trigger_in)
		&& $past(rst_n) |=> elapsed_span == 17'h0) else $error("not cleared");
	one_step_a: assert property ($changed(elapsed_span) |->
		elapsed_span == 17'h0 || elapsed_span == $past(elapsed_span) + 17'h1)
		else $error("elapsed jumped");
	tick_pace_a: assert property (elapsed_span == $past(elapsed_span) + 17'h1
		|=> elapsed_span != $past(elapsed_span) + 17'h1) else $error("too fast");
	ret_hold_a: assert property (!on_m && timer_out && !clean_signal
		|=> timer_out) else $error("output dropped");
	clr_wins_a: assert property (!on_m && clean_signal |=> !timer_out
		&& elapsed_span == 17'h0) else $error("clear ignored");
	ret_keep_a: assert property (!on_m && !clean_signal |=>
		elapsed_span >= $past(elapsed_span)) else $error("elapsed dropped");
endmodule
bind dtf_timer dtf_timer_chk chk_u (.*);

// [tb/tb_delay_timer_functions.sv]
// Purpose: self-checking bench of the delay timer
// Assumes: shortened tick dividers
// Notes: second instance is retentive
`timescale 1ns/1ps
module tb_delay_timer_functions;
	import dtf_pkg::*;
	logic clk_sys = 0, rst_n = 0, trigger_in = 0, clean_signal = 1;
	logic on_use_ref = 0, off_use_ref = 0, timer_out, r_out;
	dtf_mode_type mode = DTF_MODE_RETON;
	dtf_base_type time_base = DTF_BASE_FAST;
	logic [SPAN_W-1:0] on_const_span = 17'h3, off_const_span = 17'h2;
	logic [SPAN_W-1:0] elapsed_span, r_el;
	logic [31:0] ld = 32'h0, live;
	int fails = 0, tests_run = 0, cyc = 0, n;
	dtf_nbr_blk nbr_u (.clk_sys(clk_sys), .load(ld), .live(live));
	dtf_timer #(.DIV_10MS(2), .DIV_1S(3), .DIV_1MIN(2)) dut_u (.*,
		.on_ref_value(live), .off_ref_value(live));
	dtf_timer #(.RETENTIVE(1'b1), .DIV_10MS(2), .DIV_1S(3), .DIV_1MIN(2))
		dut_r (.*, .on_ref_value(live), .off_ref_value(live),
		.timer_out(r_out), .elapsed_span(r_el));
	initial forever #5 clk_sys = ~clk_sys;
	task print_verdict();
		if (fails == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			print_verdict();
		end
	end
	task chk(string nm, logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task step(int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task wait_out(logic v);
		n = 0;
		while (timer_out !== v && n < 60) begin
			step(1);
			n++;
		end
	endtask
	task t_ret();
		trigger_in = 1;
		step(1);
		clean_signal = 0;
		step(6);
		chk("clr_rise", {timer_out, elapsed_span}, 32'h0);
		trigger_in = 0;
		step(1);
		trigger_in = 1;
		step(1);
		trigger_in = 0;
		step(2);
		trigger_in = 1;
		step(1);
		trigger_in = 0;
		wait_out(1);
		chk("ret_set", {timer_out, elapsed_span}, 32'h20003);
		rst_n = 0;
		step(1);
		rst_n = 1;
		step(1);
		chk("pwr_keep", {r_out, r_el}, 32'h20003);
		chk("pwr_lose", {timer_out, elapsed_span}, 32'h0);
		clean_signal = 1;
		step(1);
		clean_signal = 0;
		chk("ret_clr", {r_out, r_el}, 32'h0);
	endtask
	task t_onoff();
		mode = DTF_MODE_ONOFF;
		trigger_in = 1;
		step(3);
		trigger_in = 0;
		step(8);
		chk("on_abort", {timer_out, elapsed_span}, 32'h0);
		trigger_in = 1;
		wait_out(1);
		chk("on_set", {timer_out, elapsed_span}, 32'h20003);
		trigger_in = 0;
		step(1);
		trigger_in = 1;
		step(8);
		chk("off_abort", {timer_out, elapsed_span}, 32'h20000);
		trigger_in = 0;
		wait_out(0);
		chk("off_clr", {timer_out, elapsed_span}, 32'h2);
	endtask
	task t_base();
		time_base = DTF_BASE_SEC;
		trigger_in = 1;
		wait_out(1);
		chk("sec_slow", n > 10, 32'h1);
		trigger_in = 0;
		wait_out(0);
		time_base = DTF_BASE_MIN;
		trigger_in = 1;
		wait_out(1);
		chk("min_slow", n > 25, 32'h1);
		trigger_in = 0;
		wait_out(0);
		time_base = DTF_BASE_FAST;
	endtask
	task t_ref();
		on_use_ref = 1;
		ld = 32'h28;
		step(2);
		trigger_in = 1;
		wait_out(1);
		chk("ref_span", elapsed_span, 32'h4);
		trigger_in = 0;
		wait_out(0);
		ld = 32'hfffffff6;
		step(2);
		trigger_in = 1;
		wait_out(1);
		chk("ref_neg", {timer_out, elapsed_span}, 32'h20000);
		off_use_ref = 1;
		ld = 32'h1e;
		step(2);
		trigger_in = 0;
		wait_out(0);
		chk("ref_off", {timer_out, elapsed_span}, 32'h3);
		on_use_ref = 0;
		off_use_ref = 0;
		on_const_span = 17'h1;
		trigger_in = 1;
		wait_out(1);
		chk("const_one", {timer_out, elapsed_span}, 32'h20001);
	endtask
	initial begin
		step(6);
		rst_n = 1;
		t_ret();
		t_onoff();
		t_base();
		t_ref();
		print_verdict();
	end
endmodule
